/* tidm_pkg.sv */
package tidm_pkg;
   localparam int unsigned CW_W = 16;
   localparam int unsigned ACC_W = 32;
   localparam int unsigned NUM_CLASSES = 9;
   localparam int unsigned DELAY_LSB = 3;
   localparam logic [15:0] RESERVED_MASK = 16'hf007;
   localparam logic [15:0] DELAY_MASK = 16'h0ff8;
   localparam logic [15:0] CW_RESET = 16'h0000;
   localparam logic [15:0] ERROR_ID = 16'h1a4b;

   typedef enum logic [15:0] {
      TIDM_FN_LOAD = 16'h0001,
      TIDM_FN_SET_ONES = 16'h0002,
      TIDM_FN_SET_ZEROS = 16'h0003
   } tidm_fn_t;

   typedef enum logic [0:0] {
      TIDM_RUN = 1'b0,
      TIDM_STOP = 1'b1
   } tidm_state_t;
endpackage : tidm_pkg

/* tidm_class_slot.sv */
module tidm_class_slot (
   input wire logic core_clk_i,
   input wire logic rst_n_i,
   input wire logic tick_i,
   input wire logic boundary_i,
   input wire logic delay_i,
   input wire logic enable_i,
   input wire logic handler_done_i,
   output logic insert_o,
   output logic collision_o,
   output logic pending_o,
   output logic running_o
);
   logic pending_q;
   logic insert_q;
   logic collision_q;
   logic running_q;
   logic fire;

   // Held requests wait for a boundary with the delay bit clear
   assign fire = boundary_i && pending_q && !delay_i && enable_i && !running_q; // RQ9 RQ11

   // A fresh tick wins over the clear caused by insertion
   always_ff @(posedge core_clk_i or negedge rst_n_i) begin
      if (!rst_n_i) begin
         pending_q <= 1'b0;
      end else begin
         pending_q <= (pending_q && !fire) || tick_i; // RQ9 RQ11
      end
   end

   always_ff @(posedge core_clk_i or negedge rst_n_i) begin
      if (!rst_n_i) begin
         insert_q <= 1'b0;
      end else begin
         insert_q <= fire;
      end
   end

   always_ff @(posedge core_clk_i or negedge rst_n_i) begin
      if (!rst_n_i) begin
         collision_q <= 1'b0;
      end else begin
         collision_q <= tick_i && pending_q && delay_i; // RQ12
      end
   end

   // A started handler is never cut short by the delay bit
   always_ff @(posedge core_clk_i or negedge rst_n_i) begin
      if (!rst_n_i) begin
         running_q <= 1'b0;
      end else if (fire) begin
         running_q <= 1'b1;
      end else if (handler_done_i) begin
         running_q <= 1'b0; // RQ10
      end
   end

   assign insert_o = insert_q;
   assign collision_o = collision_q;
   assign pending_o = pending_q;
   assign running_o = running_q;

   sequence s_held_request;
      pending_q && delay_i;
   endsequence

   sequence s_released_boundary;
      pending_q && !delay_i && boundary_i && enable_i && !running_q;
   endsequence

   a_held_no_insert: assert property (@(posedge core_clk_i) disable iff (!rst_n_i) // RQ9
      s_held_request |=> !insert_q && pending_q)
      else $error("held request was inserted or dropped");

   a_release_insert: assert property (@(posedge core_clk_i) disable iff (!rst_n_i) // RQ11
      s_released_boundary |=> insert_q)
      else $error("released request not inserted at boundary");

   a_collision_flag: assert property (@(posedge core_clk_i) disable iff (!rst_n_i) // RQ12
      s_held_request ##0 tick_i |=> collision_o)
      else $error("second held request gave no collision");

   a_running_kept: assert property (@(posedge core_clk_i) disable iff (!rst_n_i) // RQ10
      running_q && delay_i && !handler_done_i |=> running_q)
      else $error("running handler stopped by delay bit");
endmodule : tidm_class_slot

/* tidm_delay_mask.sv */
// Contract
// RQ1: Keep a 16-bit delay word; bits 3..11 hold back 10 ms up to 5 s.
// RQ2: Caller keeps bits 0..2 and 12..15 zero; they are reserved.
// RQ3: Function 1 copies accumulator one into the delay word.
// RQ4: Function 2 sets bits where mask is one, returns the new word.
// RQ5: Function 3 sets bits where mask is zero, returns the new word.
// RQ6: Bad function code or set reserved mask bit is an error.
// RQ7: On error call handler if loaded; always write 1A4B to low accumulator.
// RQ8: On error with no handler loaded, enter the stop state.
// RQ9: Delayed interrupts keep registering and pending but are not inserted.
// RQ10: A handler already running when delayed runs to completion.
// RQ11: Clearing a delay bit inserts held requests at the next boundary; here a request also waits while its class handler is still running.
// RQ12: A second request while held back flags a time interrupt collision.
// RQ13: Caller reads the word using function 2 or 3 with zero mask; here function 3 with zero mask sets bits 3..11.
// RQ14: Mirror the delay state in a readable status word.
// RQ15: Errors leave the word unchanged; the word resets to all zeros.
module tidm_delay_mask #(
   parameter int unsigned NUM_CLASSES = tidm_pkg::NUM_CLASSES
) (
   input wire logic core_clk_i,
   input wire logic rst_n_i,
   input wire logic service_call_i,
   input wire logic [15:0] accumulator_two_low_i,
   input wire logic [31:0] accumulator_one_i,
   input wire logic handler_loaded_i,
   input wire logic [NUM_CLASSES-1:0] interval_tick_i,
   input wire logic boundary_i,
   input wire logic [NUM_CLASSES-1:0] handler_done_i,
   output logic service_done_o,
   output logic [31:0] accumulator_one_o,
   output logic error_o,
   output logic runtime_error_call_o,
   output logic stopped_o,
   output logic [15:0] delay_status_word_o,
   output logic [NUM_CLASSES-1:0] insert_o,
   output logic [NUM_CLASSES-1:0] collision_o,
   output logic [NUM_CLASSES-1:0] pending_o,
   output logic [NUM_CLASSES-1:0] running_o
);
   logic [15:0] interval_interrupt_delay_word_q;
   logic [15:0] cw_d;
   logic [15:0] mask;
   logic [15:0] fn;
   logic fn_ok;
   logic reserved_set;
   logic call_err;
   logic call_ok;
   logic [15:0] status_q;
   logic done_q;
   logic [31:0] acc_q;
   logic err_q;
   logic handler_call_q;
   tidm_pkg::tidm_state_t state_q;
   tidm_pkg::tidm_state_t state_d;
   logic running_enable;
   logic [NUM_CLASSES-1:0] class_delay;

   assign mask = accumulator_one_i[15:0];
   assign fn = accumulator_two_low_i;
   assign fn_ok = (fn == tidm_pkg::TIDM_FN_LOAD) || (fn == tidm_pkg::TIDM_FN_SET_ONES)
      || (fn == tidm_pkg::TIDM_FN_SET_ZEROS);
   assign reserved_set = |(mask & tidm_pkg::RESERVED_MASK); // RQ2
   // Calls are ignored once halted
   assign running_enable = (state_q == tidm_pkg::TIDM_RUN);
   assign call_err = service_call_i && running_enable && (!fn_ok || reserved_set); // RQ6
   assign call_ok = service_call_i && running_enable && fn_ok && !reserved_set;

   // Next control word; reserved positions stay zero because calls with reserved mask bits are refused and function 3 is masked with DELAY_MASK
   always_comb begin
      cw_d = interval_interrupt_delay_word_q;
      if (call_ok) begin
         case (fn)
            tidm_pkg::TIDM_FN_LOAD: begin
               cw_d = mask; // RQ3
            end
            tidm_pkg::TIDM_FN_SET_ONES: begin
               cw_d = interval_interrupt_delay_word_q | mask; // RQ4
            end
            tidm_pkg::TIDM_FN_SET_ZEROS: begin
               cw_d = interval_interrupt_delay_word_q | (~mask & tidm_pkg::DELAY_MASK); // RQ5
            end
            default: begin
               cw_d = interval_interrupt_delay_word_q;
            end
         endcase
      end
   end

   always_ff @(posedge core_clk_i or negedge rst_n_i) begin
      if (!rst_n_i) begin
         interval_interrupt_delay_word_q <= tidm_pkg::CW_RESET; // RQ15
      end else begin
         interval_interrupt_delay_word_q <= cw_d; // RQ1 RQ15
      end
   end

   always_ff @(posedge core_clk_i or negedge rst_n_i) begin
      if (!rst_n_i) begin
         status_q <= tidm_pkg::CW_RESET;
      end else begin
         status_q <= cw_d; // RQ14
      end
   end

   // Result returned to the caller one cycle after the call
   always_ff @(posedge core_clk_i or negedge rst_n_i) begin
      if (!rst_n_i) begin
         acc_q <= 32'h0000_0000;
      end else if (call_err) begin
         acc_q <= {accumulator_one_i[31:16], tidm_pkg::ERROR_ID}; // RQ7
      end else if (call_ok) begin
         if (fn == tidm_pkg::TIDM_FN_LOAD) begin
            acc_q <= accumulator_one_i; // RQ3
         end else begin
            acc_q <= {accumulator_one_i[31:16], cw_d}; // RQ4 RQ5 RQ13
         end
      end
   end

   always_ff @(posedge core_clk_i or negedge rst_n_i) begin
      if (!rst_n_i) begin
         done_q <= 1'b0;
         err_q <= 1'b0;
         handler_call_q <= 1'b0;
      end else begin
         done_q <= call_ok || call_err;
         err_q <= call_err; // RQ6
         handler_call_q <= call_err && handler_loaded_i; // RQ7
      end
   end

   always_comb begin
      state_d = state_q;
      case (state_q)
         tidm_pkg::TIDM_RUN: begin
            if (call_err && !handler_loaded_i) begin
               state_d = tidm_pkg::TIDM_STOP; // RQ8
            end
         end
         tidm_pkg::TIDM_STOP: begin
            state_d = tidm_pkg::TIDM_STOP;
         end
         default: begin
            state_d = tidm_pkg::TIDM_STOP;
         end
      endcase
   end

   always_ff @(posedge core_clk_i or negedge rst_n_i) begin
      if (!rst_n_i) begin
         state_q <= tidm_pkg::TIDM_RUN;
      end else begin
         state_q <= state_d;
      end
   end

   assign class_delay = interval_interrupt_delay_word_q[tidm_pkg::DELAY_LSB +: NUM_CLASSES]; // RQ1

   for (genvar k = 0; k < NUM_CLASSES; k++) begin : g_class
      tidm_class_slot u_slot (
         .core_clk_i(core_clk_i),
         .rst_n_i(rst_n_i),
         .tick_i(interval_tick_i[k]),
         .boundary_i(boundary_i),
         .delay_i(class_delay[k]),
         .enable_i(running_enable),
         .handler_done_i(handler_done_i[k]),
         .insert_o(insert_o[k]),
         .collision_o(collision_o[k]),
         .pending_o(pending_o[k]),
         .running_o(running_o[k])
      );
   end

   assign service_done_o = done_q;
   assign accumulator_one_o = acc_q;
   assign error_o = err_q;
   assign runtime_error_call_o = handler_call_q;
   assign stopped_o = (state_q == tidm_pkg::TIDM_STOP);
   assign delay_status_word_o = status_q;

   sequence s_good_call(logic [15:0] code);
      call_ok && fn == code;
   endsequence

   sequence s_bad_call;
      call_err;
   endsequence

   a_fn_load: assert property (@(posedge core_clk_i) disable iff (!rst_n_i) // RQ3
      s_good_call(tidm_pkg::TIDM_FN_LOAD) |=>
      interval_interrupt_delay_word_q == $past(mask)
      && accumulator_one_o == $past(accumulator_one_i))
      else $error("function 1 did not load the word");

   a_fn_set_ones: assert property (@(posedge core_clk_i) disable iff (!rst_n_i) // RQ4
      s_good_call(tidm_pkg::TIDM_FN_SET_ONES) |=> interval_interrupt_delay_word_q ==
      ($past(interval_interrupt_delay_word_q) | $past(mask))
      && accumulator_one_o[15:0] == interval_interrupt_delay_word_q)
      else $error("function 2 result wrong");

   a_fn_set_zeros: assert property (@(posedge core_clk_i) disable iff (!rst_n_i) // RQ5
      s_good_call(tidm_pkg::TIDM_FN_SET_ZEROS) |=> interval_interrupt_delay_word_q ==
      ($past(interval_interrupt_delay_word_q) | (~$past(mask) & tidm_pkg::DELAY_MASK))
      && accumulator_one_o[15:0] == interval_interrupt_delay_word_q)
      else $error("function 3 result wrong");

   a_error_id: assert property (@(posedge core_clk_i) disable iff (!rst_n_i) // RQ7
      s_bad_call |=> error_o && service_done_o && accumulator_one_o[15:0] == tidm_pkg::ERROR_ID)
      else $error("error identifier not returned");

   a_error_keeps: assert property (@(posedge core_clk_i) disable iff (!rst_n_i) // RQ15
      s_bad_call |=> $stable(interval_interrupt_delay_word_q))
      else $error("error changed the delay word");

   a_error_detect: assert property (@(posedge core_clk_i) disable iff (!rst_n_i) // RQ6
      service_call_i && !stopped_o && (mask & tidm_pkg::RESERVED_MASK) != 16'h0000 |=> error_o)
      else $error("reserved bit not refused");

   a_stop_entry: assert property (@(posedge core_clk_i) disable iff (!rst_n_i) // RQ8
      s_bad_call ##0 !handler_loaded_i |=> stopped_o && !runtime_error_call_o ##1 stopped_o)
      else $error("missing handler did not stop");

   a_handler_call: assert property (@(posedge core_clk_i) disable iff (!rst_n_i) // RQ7
      s_bad_call ##0 handler_loaded_i |=> runtime_error_call_o && !stopped_o)
      else $error("loaded handler not invoked");

   a_status_mirror: assert property (@(posedge core_clk_i) disable iff (!rst_n_i) // RQ14 RQ1
      call_ok |=> delay_status_word_o == interval_interrupt_delay_word_q
      && (delay_status_word_o & tidm_pkg::RESERVED_MASK) == 16'h0000)
      else $error("status word does not mirror delay word");

   // A function 2 call with an empty mask only reads the word back
   sequence s_read_call;
      s_good_call(tidm_pkg::TIDM_FN_SET_ONES) ##0 mask == 16'h0000;
   endsequence

   a_zero_read: assert property (@(posedge core_clk_i) disable iff (!rst_n_i) // RQ4
      s_read_call |=> $stable(interval_interrupt_delay_word_q)
      && accumulator_one_o[15:0] == interval_interrupt_delay_word_q)
      else $error("read call changed the word or returned another value");

   a_bad_code: assert property (@(posedge core_clk_i) disable iff (!rst_n_i) // RQ6
      service_call_i && !stopped_o && (fn == 16'h0000 || fn > 16'h0003)
      |=> error_o && $stable(interval_interrupt_delay_word_q))
      else $error("bad function code not refused");

   a_good_clean: assert property (@(posedge core_clk_i) disable iff (!rst_n_i) // RQ6
      call_ok |=> !error_o && !runtime_error_call_o)
      else $error("good call flagged as error");

   a_error_with_done: assert property (@(posedge core_clk_i) disable iff (!rst_n_i) // RQ6
      error_o |-> service_done_o)
      else $error("error shown without a result");

   a_handler_on_error: assert property (@(posedge core_clk_i) disable iff (!rst_n_i) // RQ7
      runtime_error_call_o |-> error_o && !stopped_o)
      else $error("handler invoked without an error");

   a_upper_kept: assert property (@(posedge core_clk_i) disable iff (!rst_n_i) // RQ7
      service_call_i && !stopped_o
      |=> accumulator_one_o[31:16] == $past(accumulator_one_i[31:16]))
      else $error("upper accumulator half changed");

   a_answer_next: assert property (@(posedge core_clk_i) disable iff (!rst_n_i) // RQ3
      service_call_i && !stopped_o |=> service_done_o)
      else $error("accepted call gave no result");

   // Outputs that must hold between accepted calls
   a_acc_hold: assert property (@(posedge core_clk_i) disable iff (!rst_n_i) // RQ4
      !(service_call_i && !stopped_o) |=> $stable(accumulator_one_o))
      else $error("accumulator changed without a call");

   a_word_hold: assert property (@(posedge core_clk_i) disable iff (!rst_n_i) // RQ15
      !service_call_i |=> $stable(interval_interrupt_delay_word_q))
      else $error("delay word changed without a call");

   a_reserved_zero: assert property (@(posedge core_clk_i) disable iff (!rst_n_i) // RQ1
      (interval_interrupt_delay_word_q & tidm_pkg::RESERVED_MASK) == 16'h0000)
      else $error("reserved bit set in delay word");

   a_status_always: assert property (@(posedge core_clk_i) disable iff (!rst_n_i) // RQ14
      delay_status_word_o == interval_interrupt_delay_word_q)
      else $error("status word differs from delay word");

   // Halted core answers nothing and inserts nothing
   a_stop_quiet: assert property (@(posedge core_clk_i) disable iff (!rst_n_i) // RQ8
      stopped_o |=> stopped_o && !service_done_o
      && !error_o && !runtime_error_call_o)
      else $error("halted core left stop or answered a call");

   a_stop_no_insert: assert property (@(posedge core_clk_i) disable iff (!rst_n_i) // RQ8
      stopped_o |=> insert_o == '0)
      else $error("insertion while halted");

   a_delay_blocks: assert property (@(posedge core_clk_i) disable iff (!rst_n_i) // RQ9
      (insert_o & $past(class_delay)) == '0)
      else $error("delayed class was inserted");

   a_insert_boundary: assert property (@(posedge core_clk_i) disable iff (!rst_n_i) // RQ11
      |insert_o
      |-> $past(boundary_i) && !$past(stopped_o))
      else $error("insertion away from a boundary");

   a_collision_held: assert property (@(posedge core_clk_i) disable iff (!rst_n_i) // RQ12
      (collision_o & ~$past(class_delay)) == '0)
      else $error("collision flagged for a class not held back");
endmodule : tidm_delay_mask

/* tidm_handler_model.sv */
module tidm_handler_model #(
   parameter int LAT = 10
) (
   input wire logic core_clk_i,
   input wire logic rst_n_i,
   input wire logic [8:0] insert_i,
   output logic [8:0] handler_done_o
);
   timeunit 1ns;
   timeprecision 1ps;
   int cnt [9];

   // Each inserted handler runs LAT cycles, then reports completion once
   always @(posedge core_clk_i or negedge rst_n_i) begin
      if (!rst_n_i) begin
         handler_done_o <= 9'h000;
         foreach (cnt[k]) cnt[k] <= 0;
      end else begin
         for (int k = 0; k < 9; k++) begin
            handler_done_o[k] <= (cnt[k] == 1);
            if (insert_i[k]) cnt[k] <= LAT;
            else if (cnt[k] > 0) cnt[k] <= cnt[k] - 1;
         end
      end
   end
endmodule : tidm_handler_model

/* test_time_interrupt_delay_mask.sv */
module test_time_interrupt_delay_mask;
   timeunit 1ns;
   timeprecision 1ps;
   logic core_clk_i = 1'b0, rst_n_i = 1'b0, service_call_i = 1'b0;
   logic handler_loaded_i = 1'b0, boundary_i = 1'b0, service_done_o, error_o;
   logic runtime_error_call_o, stopped_o;
   logic [15:0] fn_i = 16'h0000, w, delay_status_word_o;
   logic [31:0] acc_i = 32'h0000_0000, accumulator_one_o;
   logic [8:0] tick = 9'h000, hdone, insert_o, collision_o, pending_o, running_o;
   logic [33:0] exp_q [$], e;
   int fails = 0, n_compared = 0, seed = 38, ins [9], col [9];

   tidm_delay_mask uut (.core_clk_i(core_clk_i), .rst_n_i(rst_n_i),
      .service_call_i(service_call_i), .accumulator_two_low_i(fn_i),
      .accumulator_one_i(acc_i), .handler_loaded_i(handler_loaded_i),
      .interval_tick_i(tick), .boundary_i(boundary_i), .handler_done_i(hdone),
      .service_done_o(service_done_o), .accumulator_one_o(accumulator_one_o),
      .error_o(error_o), .runtime_error_call_o(runtime_error_call_o),
      .stopped_o(stopped_o), .delay_status_word_o(delay_status_word_o),
      .insert_o(insert_o), .collision_o(collision_o), .pending_o(pending_o),
      .running_o(running_o));
   tidm_handler_model #(.LAT(10)) far (.core_clk_i(core_clk_i), .rst_n_i(rst_n_i),
      .insert_i(insert_o), .handler_done_o(hdone));

   initial forever #20 core_clk_i = ~core_clk_i;

   task chk(input string nm, input logic [33:0] x, input logic [33:0] g);
      n_compared++;
      if (g !== x) begin
         fails++;
         $display("[ERR] %s expected %h seen %h", nm, x, g);
      end
   endtask : chk

   task complete_run();
      if (fails == 0 && n_compared > 0)
         $display("Simulation passed");
      else
         $display("Simulation failed");
      $finish;
   endtask : complete_run

   task call(input logic [15:0] fn, input logic [31:0] a, input logic hl);
      logic [15:0] m;
      logic [33:0] x;
      @(posedge core_clk_i);
      service_call_i <= 1'b1;
      fn_i <= fn;
      acc_i <= a;
      handler_loaded_i <= hl;
      m = a[15:0];
      if ((m & tidm_pkg::RESERVED_MASK) != 16'h0000 || fn == 16'h0000 || fn > 16'h0003) begin
         x = {a[31:16], tidm_pkg::ERROR_ID, 1'b1, hl};
      end else begin
         if (fn == 16'h0001) w = m;
         else if (fn == 16'h0002) w = w | m;
         else w = w | (~m & tidm_pkg::DELAY_MASK);
         x = {(fn == 16'h0001) ? a : {a[31:16], w}, 2'b00};
      end
      exp_q.push_back(x);
   endtask : call

   task idle(input int n);
      repeat (n) @(posedge core_clk_i) begin
         service_call_i <= 1'b0;
         tick <= 9'h000;
         boundary_i <= 1'b0;
      end
      #1;
   endtask : idle

   // Results are matched in arrival order against the noted expectations
   always @(posedge core_clk_i) begin
      if (rst_n_i) begin
         for (int k = 0; k < 9; k++) begin
            if (insert_o[k] === 1'b1) ins[k]++;
            if (collision_o[k] === 1'b1) col[k]++;
         end
         if (service_done_o === 1'b1) begin
            e = (exp_q.size() > 0) ? exp_q.pop_front() : 34'h0;
            chk("service_result", e,
               {accumulator_one_o, error_o, runtime_error_call_o});
         end
      end
   end

   initial begin
      repeat (8) @(posedge core_clk_i);
      rst_n_i <= 1'b1;
      w = 16'h0000;
      idle(1);
      chk("status_reset", 34'h0, delay_status_word_o);
      call(16'h0001, 32'h1234_0018, 1'b1);
      call(16'h0002, 32'h0000_0020, 1'b1);
      call(16'h0003, 32'h0000_0ff0, 1'b1);
      call(16'h0002, 32'h0000_0000, 1'b1);
      idle(2);
      chk("status_word", w, delay_status_word_o);
      repeat (20) call(16'($unsigned($random(seed)) % 3 + 1),
         $random(seed) & 32'hffff_0ff8, 1'b1);
      call(16'h0000, 32'h0000_0000, 1'b1);
      call(16'h0004, 32'hffff_0008, 1'b1);
      call(16'h0002, 32'h0000_8000, 1'b1);
      call(16'h0001, 32'h0000_0001, 1'b1);
      call(16'h0003, 32'h0000_0ff8, 1'b1);
      idle(2);
      chk("status_after_err", w, delay_status_word_o);
      call(16'h0001, 32'h0000_0008, 1'b1);
      idle(2);
      tick <= 9'h001;
      idle(3);
      chk("pending_held", 34'h1, pending_o[0]);
      boundary_i <= 1'b1;
      idle(3);
      chk("held_inserts", 34'h0, ins[0]);
      tick <= 9'h001;
      idle(3);
      chk("collisions", 34'h1, col[0]);
      call(16'h0001, 32'h0000_0000, 1'b1);
      idle(2);
      boundary_i <= 1'b1;
      idle(3);
      chk("released_inserts", 34'h1, ins[0]);
      tick <= 9'h002;
      idle(2);
      boundary_i <= 1'b1;
      idle(2);
      call(16'h0002, 32'h0000_0010, 1'b1);
      idle(1);
      chk("running_kept", 34'h1, running_o[1]);
      idle(14);
      chk("running_done", 34'h0, running_o[1]);
      call(16'h0007, 32'h0000_0000, 1'b0);
      idle(3);
      chk("stopped", 34'h1, stopped_o);
      // A halted core ignores calls and inserts nothing, but still registers requests
      call(16'h0002, 32'h0000_0010, 1'b1);
      void'(exp_q.pop_back());
      tick <= 9'h004;
      idle(2);
      boundary_i <= 1'b1;
      idle(3);
      chk("acc_while_stopped", {18'h0, tidm_pkg::ERROR_ID}, accumulator_one_o);
      chk("insert_while_stopped", 34'h0, ins[2]);
      chk("pending_while_stopped", 34'h1, pending_o[2]);
      chk("status_while_stopped", w, delay_status_word_o);
      chk("results_left", 34'h0, 34'(exp_q.size()));
      complete_run();
   end

   initial begin
      #(40 * 20000);
      fails++;
      complete_run();
   end
endmodule : test_time_interrupt_delay_mask
